// *** logic/ddc_defines.vh ***
// constants of the ddc1/ddc2b hardware display data channel block
`ifndef DDC_DEFINES_VH
`define DDC_DEFINES_VH
// register byte offsets
`define DDC_OFS_CTRL 8'h00
`define DDC_OFS_AHB 8'h04
`define DDC_OFS_STAT 8'h08
// control register fields
`define DDC_CTRL_CFG_LSB 0
`define DDC_CTRL_EN_BIT 3
`define DDC_CTRL_WP_BIT 4
`define DDC_CTRL_EDE_BIT 5
`define DDC_CTRL_EDF_BIT 6
`define DDC_CTRL_RST 3'h0
`define DDC_AHB_RST 8'h00
// status register fields
`define DDC_STAT_MODE_LSB 8
`define DDC_STAT_I2C_LSB 10
// configuration codes
`define DDC_CF_V2 3'h0
`define DDC_CF_V2_NODDC1 3'h4
`define DDC_CF_PD 3'h1
`define DDC_CF_PD_V2 3'h2
`define DDC_CF_PD_V2_NODDC1 3'h6
`define DDC_CF_FPDI 3'h3
// device addresses, 7 bit
`define DDC_DEV_V1 7'h50
`define DDC_DEV_PD 7'h51
`define DDC_DEV_FP 7'h53
// operating modes
`define DDC_MODE_OFF 2'h0
`define DDC_MODE_DDC1 2'h1
`define DDC_MODE_TRANS 2'h2
`define DDC_MODE_DDC2 2'h3
// timing
`define DDC_CLK_HZ 40000000
`define DDC_TICK_US 1000
`define DDC_TICK_CYC ((`DDC_CLK_HZ / 1000000) * `DDC_TICK_US)
`define DDC_TIMEOUT_MS 2000
`define DDC_TIMEOUT_TICKS (`DDC_TIMEOUT_MS * 1000 / `DDC_TICK_US)
`define DDC_TRANS_VSYNC 8'h80
`define DDC_SYNC_PULSES 4'h9
`define DDC_BYTE_PULSES 4'h9
`define DDC_STALL_CYC 2'h2
`endif

// *** logic/ddc_hw_iface.v ***
// ddc1/ddc2b edid slave with dma path and axi4-lite registers
`timescale 1ns/1ps
`include "ddc_defines.vh"
module ddc_hw_iface #(
    parameter TICK_CYC = `DDC_TICK_CYC,
    parameter TIMEOUT_TICKS = `DDC_TIMEOUT_TICKS
) (
    input wire CLK_I,
    input wire RESETN_I,
    input wire [7:0] S_AXI_AWADDR_I,
    input wire S_AXI_AWVALID_I,
    output reg S_AXI_AWREADY_O,
    input wire [31:0] S_AXI_WDATA_I,
    input wire [3:0] S_AXI_WSTRB_I,
    input wire S_AXI_WVALID_I,
    output reg S_AXI_WREADY_O,
    output reg [1:0] S_AXI_BRESP_O,
    output reg S_AXI_BVALID_O,
    input wire S_AXI_BREADY_I,
    input wire [7:0] S_AXI_ARADDR_I,
    input wire S_AXI_ARVALID_I,
    output reg S_AXI_ARREADY_O,
    output reg [31:0] S_AXI_RDATA_O,
    output reg [1:0] S_AXI_RRESP_O,
    output reg S_AXI_RVALID_O,
    input wire S_AXI_RREADY_I,
    input wire SCL_I,
    input wire SDA_I,
    output reg SDA_O,
    output reg SDA_OE_O,
    input wire VSYNC_CLOCK_IN_I,
    output reg [15:0] MEM_ADDR_O,
    output reg [7:0] MEM_WDATA_O,
    output reg MEM_RD_O,
    output reg MEM_WR_O,
    input wire [7:0] MEM_RDATA_I,
    output reg CPU_STALL_O,
    output reg IRQ_O
);
    // ************************************************
    // registers and synchronisers
    // ************************************************
    reg [2:0] config_select_q;
    reg hw_iface_enable_q;
    reg wp_q;
    reg ede_q;
    reg edf_q;
    reg [7:0] address_high_base_q;
    reg [2:0] scl_s_q;
    reg [2:0] sda_s_q;
    reg [2:0] vs_s_q;
    reg [1:0] mode_q;
    reg [1:0] i2c_q;
    reg [3:0] bit_q;
    reg [7:0] shift_q;
    reg [7:0] tx_q;
    reg [7:0] alr_q;
    reg v2_q;
    reg rd_q;
    reg sub_q;
    reg drv_q;
    reg d1_sync_q;
    reg [3:0] d1_cnt_q;
    reg [7:0] tr_vs_q;
    reg [15:0] tick_q;
    reg [15:0] tmo_q;
    reg [1:0] dma_cnt_q;
    reg dma_wr_q;
    reg en_d_q;
    reg [7:0] awaddr_q;
    reg aw_got_q;
    reg [31:0] wdata_q;
    reg [3:0] wstrb_q;
    reg w_got_q;
    reg edf_set;
    reg dma_rd_go;
    reg dma_wr_go;
    wire scl = scl_s_q[1];
    wire sda = sda_s_q[1];
    wire scl_rise = scl & ~scl_s_q[2];
    wire scl_fall = ~scl & scl_s_q[2];
    wire vs_rise = vs_s_q[1] & ~vs_s_q[2];
    wire i2c_on = (mode_q == `DDC_MODE_TRANS) || (mode_q == `DDC_MODE_DDC2);
    wire start_ev = i2c_on & scl & scl_s_q[2] & ~sda & sda_s_q[2];
    wire stop_ev = i2c_on & scl & scl_s_q[2] & sda & ~sda_s_q[2];
    wire ddc1_ok = (config_select_q == `DDC_CF_V2) || (config_select_q == `DDC_CF_PD_V2);
    wire [6:0] dev = shift_q[7:1];
    wire m_v1 = (dev == `DDC_DEV_V1) && !config_select_q[0];
    wire m_pd = (dev == `DDC_DEV_PD) && ((config_select_q == `DDC_CF_PD) ||
        (config_select_q == `DDC_CF_PD_V2) || (config_select_q == `DDC_CF_PD_V2_NODDC1));
    wire m_fp = (dev == `DDC_DEV_FP) && (config_select_q == `DDC_CF_FPDI);
    wire dev_match = m_v1 | m_pd | m_fp;
    wire [7:0] alr_inc = v2_q ? alr_q + 8'h01 : {alr_q[7], alr_q[6:0] + 7'h01};
    wire alr_last = v2_q ? (alr_q == 8'hff) : (alr_q[6:0] == 7'h7f);
    wire [7:0] ahb_eff = (config_select_q[1:0] == 2'b10) ?
        {address_high_base_q[7:1], ~v2_q} : address_high_base_q;
    wire tmo_hit = (tick_q == TICK_CYC[15:0] - 16'h0001) && (tmo_q == TIMEOUT_TICKS[15:0] - 16'h0001);

    always @(posedge CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            scl_s_q <= 3'h7;
            sda_s_q <= 3'h7;
            vs_s_q <= 3'h0;
        end else begin
            scl_s_q <= {scl_s_q[1:0], SCL_I};
            sda_s_q <= {sda_s_q[1:0], SDA_I};
            vs_s_q <= {vs_s_q[1:0], VSYNC_CLOCK_IN_I};
        end
    end

    // ************************************************
    // mode, ddc1 shifter, i2c slave
    // ************************************************
    always @(posedge CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            mode_q <= `DDC_MODE_OFF;
            i2c_q <= 2'h0;
            bit_q <= 4'h0;
            shift_q <= 8'h00;
            alr_q <= 8'h00;
            v2_q <= 1'b0;
            rd_q <= 1'b0;
            sub_q <= 1'b0;
            drv_q <= 1'b0;
            d1_sync_q <= 1'b1;
            d1_cnt_q <= 4'h0;
            tr_vs_q <= 8'h00;
            tick_q <= 16'h0000;
            tmo_q <= 16'h0000;
            en_d_q <= 1'b0;
            dma_rd_go <= 1'b0;
            dma_wr_go <= 1'b0;
            edf_set <= 1'b0;
        end else begin
            en_d_q <= hw_iface_enable_q;
            dma_rd_go <= 1'b0;
            dma_wr_go <= 1'b0;
            edf_set <= 1'b0;
            if (!hw_iface_enable_q) begin
                mode_q <= `DDC_MODE_OFF;
                i2c_q <= 2'h0;
                drv_q <= 1'b0;
            end else if (!en_d_q) begin
                alr_q <= 8'h00;
                i2c_q <= 2'h0;
                drv_q <= 1'b0;
                if (ddc1_ok) begin
                    mode_q <= `DDC_MODE_DDC1;
                    v2_q <= 1'b0;
                    d1_sync_q <= 1'b1;
                    d1_cnt_q <= 4'h0;
                    dma_rd_go <= 1'b1;
                end else begin
                    mode_q <= `DDC_MODE_DDC2;
                end
            end else if (mode_q == `DDC_MODE_DDC1) begin
                if (scl_fall) begin
                    mode_q <= `DDC_MODE_TRANS;
                    drv_q <= 1'b0;
                    tr_vs_q <= 8'h00;
                    tick_q <= 16'h0000;
                    tmo_q <= 16'h0000;
                    i2c_q <= 2'h0;
                end else if (vs_rise) begin
                    if (d1_sync_q) begin
                        drv_q <= 1'b0;
                        if (d1_cnt_q == `DDC_SYNC_PULSES - 4'h1) begin
                            d1_sync_q <= 1'b0;
                            d1_cnt_q <= 4'h0;
                        end else begin
                            d1_cnt_q <= d1_cnt_q + 4'h1;
                        end
                    end else if (d1_cnt_q == `DDC_BYTE_PULSES - 4'h1) begin
                        drv_q <= 1'b0;
                        d1_cnt_q <= 4'h0;
                        alr_q <= alr_inc;
                        dma_rd_go <= 1'b1;
                    end else begin
                        drv_q <= ~tx_q[3'h7 - d1_cnt_q[2:0]];
                        d1_cnt_q <= d1_cnt_q + 4'h1;
                    end
                end
            end else if (i2c_on) begin
                if (mode_q == `DDC_MODE_TRANS) begin
                    if (scl_rise || scl_fall) begin
                        tr_vs_q <= 8'h00;
                        tick_q <= 16'h0000;
                        tmo_q <= 16'h0000;
                    end else begin
                        if (vs_rise) begin
                            tr_vs_q <= tr_vs_q + 8'h01;
                        end
                        if (tick_q == TICK_CYC[15:0] - 16'h0001) begin
                            tick_q <= 16'h0000;
                            tmo_q <= tmo_q + 16'h0001;
                        end else begin
                            tick_q <= tick_q + 16'h0001;
                        end
                        if ((vs_rise && tr_vs_q == `DDC_TRANS_VSYNC - 8'h01) || tmo_hit) begin
                            mode_q <= `DDC_MODE_DDC1;
                            i2c_q <= 2'h0;
                            drv_q <= 1'b0;
                            alr_q <= 8'h00;
                            v2_q <= 1'b0;
                            d1_cnt_q <= 4'h0;
                            dma_rd_go <= 1'b1;
                        end
                    end
                end
                if (start_ev) begin
                    i2c_q <= 2'h1;
                    bit_q <= 4'h0;
                    drv_q <= 1'b0;
                end else if (stop_ev) begin
                    i2c_q <= 2'h0;
                    drv_q <= 1'b0;
                end else if (i2c_q != 2'h0 && scl_rise) begin
                    if (bit_q < 4'h8) begin
                        shift_q <= {shift_q[6:0], sda};
                        bit_q <= bit_q + 4'h1;
                    end else begin
                        bit_q <= 4'h9;
                        if (i2c_q == 2'h3) begin
                            alr_q <= alr_inc;
                            if (sda) begin
                                i2c_q <= 2'h0;
                            end else begin
                                dma_rd_go <= 1'b1;
                            end
                        end
                    end
                end else if (i2c_q != 2'h0 && scl_fall) begin
                    if (bit_q == 4'h8) begin
                        case (i2c_q)
                            2'h1: begin
                                if (dev_match) begin
                                    drv_q <= 1'b1;
                                    mode_q <= `DDC_MODE_DDC2;
                                    v2_q <= ~m_v1;
                                    rd_q <= shift_q[0];
                                    sub_q <= ~shift_q[0];
                                    if (mode_q == `DDC_MODE_TRANS) begin
                                        alr_q <= 8'h00;
                                    end
                                    if (shift_q[0]) begin
                                        dma_rd_go <= 1'b1;
                                    end
                                end else begin
                                    i2c_q <= 2'h0;
                                end
                            end
                            2'h2: begin
                                drv_q <= 1'b1;
                                if (sub_q) begin
                                    alr_q <= shift_q;
                                    sub_q <= 1'b0;
                                end else begin
                                    alr_q <= alr_inc;
                                    dma_wr_go <= ~wp_q;
                                    edf_set <= ~wp_q & alr_last;
                                end
                            end
                            default: begin
                                drv_q <= 1'b0;
                            end
                        endcase
                    end else if (bit_q == 4'h9) begin
                        bit_q <= 4'h0;
                        if (i2c_q == 2'h1) begin
                            i2c_q <= rd_q ? 2'h3 : 2'h2;
                        end
                        drv_q <= (i2c_q == 2'h3 || (i2c_q == 2'h1 && rd_q)) ? ~tx_q[7] : 1'b0;
                    end else if (i2c_q == 2'h3) begin
                        drv_q <= ~tx_q[3'h7 - bit_q[2:0]];
                    end
                end
            end
        end
    end

    // ************************************************
    // dma path with cpu stall
    // ************************************************
    always @(posedge CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            dma_cnt_q <= 2'h0;
            dma_wr_q <= 1'b0;
            tx_q <= 8'h00;
            MEM_ADDR_O <= 16'h0000;
            MEM_WDATA_O <= 8'h00;
            MEM_RD_O <= 1'b0;
            MEM_WR_O <= 1'b0;
            CPU_STALL_O <= 1'b0;
        end else if (dma_rd_go || dma_wr_go) begin
            dma_cnt_q <= 2'h1;
            dma_wr_q <= dma_wr_go;
            MEM_ADDR_O <= {ahb_eff, dma_wr_go ? (v2_q ? alr_q - 8'h01 : {alr_q[7], alr_q[6:0] - 7'h01}) : alr_q};
            MEM_WDATA_O <= shift_q;
            MEM_RD_O <= dma_rd_go;
            MEM_WR_O <= dma_wr_go;
            CPU_STALL_O <= 1'b1;
        end else if (dma_cnt_q == `DDC_STALL_CYC - 2'h1) begin
            dma_cnt_q <= `DDC_STALL_CYC;
        end else if (dma_cnt_q == `DDC_STALL_CYC) begin
            dma_cnt_q <= 2'h0;
            if (!dma_wr_q) begin
                tx_q <= MEM_RDATA_I;
            end
            MEM_RD_O <= 1'b0;
            MEM_WR_O <= 1'b0;
            CPU_STALL_O <= 1'b0;
        end
    end

    // ************************************************
    // pins and interrupt
    // ************************************************
    always @(posedge CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            SDA_O <= 1'b0;
            SDA_OE_O <= 1'b0;
            IRQ_O <= 1'b0;
        end else begin
            SDA_O <= 1'b0;
            SDA_OE_O <= drv_q & hw_iface_enable_q;
            IRQ_O <= edf_q & ede_q;
        end
    end

    // ************************************************
    // axi4-lite slave
    // ************************************************
    wire wr_fire = aw_got_q && w_got_q && !S_AXI_BVALID_O;
    wire [5:0] wr_idx = awaddr_q[7:2];
    always @(posedge CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            S_AXI_AWREADY_O <= 1'b0;
            S_AXI_WREADY_O <= 1'b0;
            S_AXI_BVALID_O <= 1'b0;
            S_AXI_BRESP_O <= 2'h0;
            aw_got_q <= 1'b0;
            w_got_q <= 1'b0;
            awaddr_q <= 8'h00;
            wdata_q <= 32'h00000000;
            wstrb_q <= 4'h0;
            config_select_q <= `DDC_CTRL_RST;
            hw_iface_enable_q <= 1'b0;
            wp_q <= 1'b0;
            ede_q <= 1'b0;
            edf_q <= 1'b0;
            address_high_base_q <= `DDC_AHB_RST;
        end else begin
            S_AXI_AWREADY_O <= !aw_got_q && !(S_AXI_AWVALID_I && S_AXI_AWREADY_O);
            S_AXI_WREADY_O <= !w_got_q && !(S_AXI_WVALID_I && S_AXI_WREADY_O);
            if (S_AXI_AWVALID_I && S_AXI_AWREADY_O) begin
                aw_got_q <= 1'b1;
                awaddr_q <= S_AXI_AWADDR_I;
            end
            if (S_AXI_WVALID_I && S_AXI_WREADY_O) begin
                w_got_q <= 1'b1;
                wdata_q <= S_AXI_WDATA_I;
                wstrb_q <= S_AXI_WSTRB_I;
            end
            if (S_AXI_BVALID_O && S_AXI_BREADY_I) begin
                S_AXI_BVALID_O <= 1'b0;
                aw_got_q <= 1'b0;
                w_got_q <= 1'b0;
            end
            if (wr_fire) begin
                S_AXI_BVALID_O <= 1'b1;
                S_AXI_BRESP_O <= 2'h0;
                if (awaddr_q == `DDC_OFS_CTRL) begin
                    if (wstrb_q[0]) begin
                        if (!hw_iface_enable_q) begin
                            config_select_q <= wdata_q[`DDC_CTRL_CFG_LSB +: 3];
                        end
                        hw_iface_enable_q <= wdata_q[`DDC_CTRL_EN_BIT];
                        wp_q <= wdata_q[`DDC_CTRL_WP_BIT];
                        ede_q <= wdata_q[`DDC_CTRL_EDE_BIT];
                    end
                end else if (awaddr_q == `DDC_OFS_AHB) begin
                    if (wstrb_q[0]) begin
                        address_high_base_q <= wdata_q[7:0];
                    end
                end else if (awaddr_q != `DDC_OFS_STAT || wr_idx > 6'h02) begin
                    S_AXI_BRESP_O <= 2'h2;
                end
            end
            if (edf_set) begin
                edf_q <= 1'b1;
            end else if (wr_fire && awaddr_q == `DDC_OFS_CTRL && wstrb_q[0] && wdata_q[`DDC_CTRL_EDF_BIT]) begin
                edf_q <= 1'b0;
            end
        end
    end

    always @(posedge CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            S_AXI_ARREADY_O <= 1'b0;
            S_AXI_RVALID_O <= 1'b0;
            S_AXI_RDATA_O <= 32'h00000000;
            S_AXI_RRESP_O <= 2'h0;
        end else if (S_AXI_ARVALID_I && S_AXI_ARREADY_O) begin
            S_AXI_ARREADY_O <= 1'b0;
            S_AXI_RVALID_O <= 1'b1;
            S_AXI_RRESP_O <= 2'h0;
            S_AXI_RDATA_O <= 32'h00000000;
            case (S_AXI_ARADDR_I)
                `DDC_OFS_CTRL: S_AXI_RDATA_O <= {25'h0000000, edf_q, ede_q, wp_q, hw_iface_enable_q, config_select_q};
                `DDC_OFS_AHB: S_AXI_RDATA_O <= {24'h000000, address_high_base_q};
                `DDC_OFS_STAT: S_AXI_RDATA_O <= {20'h00000, i2c_q, mode_q, alr_q};
                default: S_AXI_RRESP_O <= 2'h2;
            endcase
        end else if (S_AXI_RVALID_O) begin
            if (S_AXI_RREADY_I) begin
                S_AXI_RVALID_O <= 1'b0;
                S_AXI_ARREADY_O <= 1'b1;
            end
        end else begin
            S_AXI_ARREADY_O <= 1'b1;
        end
    end
endmodule // ddc_hw_iface

// *** test/ddc_chk_sva.sv ***
// checker of dma strobes, cpu stall and register bus answers
`timescale 1ns/1ps
module ddc_chk (
    input wire CLK_I,
    input wire RESETN_I,
    input wire S_AXI_ARVALID_I,
    input wire S_AXI_ARREADY_O,
    input wire S_AXI_RVALID_O,
    input wire S_AXI_RREADY_I,
    input wire [31:0] S_AXI_RDATA_O,
    input wire S_AXI_BVALID_O,
    input wire S_AXI_BREADY_I,
    input wire [1:0] S_AXI_BRESP_O,
    input wire MEM_RD_O,
    input wire MEM_WR_O,
    input wire [15:0] MEM_ADDR_O,
    input wire CPU_STALL_O
);
    default clocking @(posedge CLK_I); endclocking
    default disable iff (!RESETN_I);
    AST_STALL_TWO: assert property ($rose(CPU_STALL_O) |-> CPU_STALL_O[*2] ##1 !CPU_STALL_O)
        else $error("stall not two cycles");
    AST_STALL_STROBE: assert property (CPU_STALL_O == (MEM_RD_O | MEM_WR_O))
        else $error("stall apart from strobes");
    AST_ONE_DIR: assert property (!(MEM_RD_O && MEM_WR_O))
        else $error("read and write together");
    AST_RD_TWO: assert property ($rose(MEM_RD_O) |=> MEM_RD_O ##1 !MEM_RD_O)
        else $error("read strobe not two cycles");
    AST_WR_ADDR: assert property (MEM_WR_O && $past(MEM_WR_O) |-> $stable(MEM_ADDR_O))
        else $error("write address moved");
    AST_R_ANSWER: assert property (S_AXI_ARVALID_I && S_AXI_ARREADY_O |=> S_AXI_RVALID_O)
        else $error("read answer late");
    AST_R_HOLD: assert property (S_AXI_RVALID_O && !S_AXI_RREADY_I |=> S_AXI_RVALID_O && $stable(S_AXI_RDATA_O))
        else $error("read data dropped");
    AST_B_HOLD: assert property (S_AXI_BVALID_O && !S_AXI_BREADY_I |=> S_AXI_BVALID_O && $stable(S_AXI_BRESP_O))
        else $error("write response dropped");
endmodule // ddc_chk
bind ddc_hw_iface ddc_chk u_chk (.CLK_I, .RESETN_I, .S_AXI_ARVALID_I, .S_AXI_ARREADY_O, .S_AXI_RVALID_O,
    .S_AXI_RREADY_I, .S_AXI_RDATA_O, .S_AXI_BVALID_O, .S_AXI_BREADY_I, .S_AXI_BRESP_O, .MEM_RD_O, .MEM_WR_O,
    .MEM_ADDR_O, .CPU_STALL_O);

// *** test/ddc_host.sv ***
// host model: vsync clock and i2c master
`timescale 1ns/1ps
module ddc_host (
    input wire clk_i,
    input wire sda_i,
    output reg scl_o = 1'b1,
    output reg sda_o = 1'b1,
    output reg vsync_o = 1'b0
);
    task vs(output reg b);
        begin
            vsync_o <= 1'b1;
            repeat (4) @(posedge clk_i);
            vsync_o <= 1'b0;
            repeat (4) @(posedge clk_i);
            b = sda_i;
        end
    endtask
    task bit_x(input reg d, output reg q);
        begin
            repeat (3) @(posedge clk_i);
            sda_o <= d;
            repeat (5) @(posedge clk_i);
            scl_o <= 1'b1;
            repeat (8) @(posedge clk_i);
            q = sda_i;
            scl_o <= 1'b0;
        end
    endtask
    task tick;
        begin
            scl_o <= 1'b0;
            repeat (8) @(posedge clk_i);
            scl_o <= 1'b1;
            repeat (8) @(posedge clk_i);
        end
    endtask
    task start;
        begin
            sda_o <= 1'b0;
            repeat (8) @(posedge clk_i);
            scl_o <= 1'b0;
        end
    endtask
    task stop;
        begin
            repeat (3) @(posedge clk_i);
            sda_o <= 1'b0;
            repeat (5) @(posedge clk_i);
            scl_o <= 1'b1;
            repeat (8) @(posedge clk_i);
            sda_o <= 1'b1;
            repeat (8) @(posedge clk_i);
        end
    endtask
    task send(input reg [7:0] d, output reg ack);
        integer i;
        reg x;
        begin
            for (i = 7; i >= 0; i = i - 1) bit_x(d[i], x);
            bit_x(1'b1, x);
            ack = !x;
        end
    endtask
    task recv(input reg ack_m, output reg [7:0] d);
        integer i;
        reg x;
        begin
            for (i = 7; i >= 0; i = i - 1) bit_x(1'b1, d[i]);
            bit_x(!ack_m, x);
        end
    endtask
endmodule // ddc_host

// *** test/tb_ddc_hw_iface.sv ***
// testbench: registers, ddc1 stream, transition and ddc2b transfers
`timescale 1ns/1ps
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin num_errors++; $display("Error %s exp %h got %h", n, e, g); end end
module tb_ddc_hw_iface;
    reg clk = 1'b0;
    reg rst_n = 1'b0;
    reg [7:0] awaddr = 8'h00, araddr = 8'h00, base, d, x, wd;
    reg awv = 0, wv = 0, bready = 0, arv = 0, rready = 0, b, a;
    reg [31:0] wdata = 0, q;
    reg [15:0] wa;
    reg [1:0] r;
    wire aw_rdy, w_rdy, bvalid, ar_rdy, rvalid, sda_oe, scl, sda_m, vs, mem_rd, mem_wr, stall, irq;
    wire [1:0] bresp, rresp;
    wire [31:0] rdata;
    wire [15:0] mem_a;
    wire [7:0] mem_wd;
    wire sda_w = sda_m & !sda_oe;
    integer num_errors = 0, tests_run = 0, i, seed = 32'h2e7d4a51;
    function [7:0] mf(input [15:0] ad);
        mf = ad[7:0] ^ ad[15:8] ^ 8'h3c;
    endfunction
    always #12.5 clk = !clk;
    always @(posedge clk) if (mem_wr) begin wa <= mem_a; wd <= mem_wd; end
    ddc_hw_iface #(.TICK_CYC(4), .TIMEOUT_TICKS(8)) DUT (.CLK_I(clk), .RESETN_I(rst_n),
        .S_AXI_AWADDR_I(awaddr), .S_AXI_AWVALID_I(awv), .S_AXI_AWREADY_O(aw_rdy), .S_AXI_WDATA_I(wdata),
        .S_AXI_WSTRB_I(4'h1), .S_AXI_WVALID_I(wv), .S_AXI_WREADY_O(w_rdy), .S_AXI_BRESP_O(bresp),
        .S_AXI_BVALID_O(bvalid), .S_AXI_BREADY_I(bready), .S_AXI_ARADDR_I(araddr), .S_AXI_ARVALID_I(arv),
        .S_AXI_ARREADY_O(ar_rdy), .S_AXI_RDATA_O(rdata), .S_AXI_RRESP_O(rresp), .S_AXI_RVALID_O(rvalid),
        .S_AXI_RREADY_I(rready), .SCL_I(scl), .SDA_I(sda_w), .SDA_O(), .SDA_OE_O(sda_oe),
        .VSYNC_CLOCK_IN_I(vs), .MEM_ADDR_O(mem_a), .MEM_WDATA_O(mem_wd), .MEM_RD_O(mem_rd), .MEM_WR_O(mem_wr),
        .MEM_RDATA_I(mf(mem_a)), .CPU_STALL_O(stall), .IRQ_O(irq));
    ddc_host u_host (.clk_i(clk), .sda_i(sda_w), .scl_o(scl), .sda_o(sda_m), .vsync_o(vs));
    task results;
        begin
            $display("checks %0d errors %0d", tests_run, num_errors);
            if (num_errors == 0 && tests_run > 0) $display("DONE - PASS");
            else $display("DONE - FAIL");
            $finish;
        end
    endtask
    task axi(input reg w, input reg [7:0] ad, input reg [31:0] dt);
        integer n;
        reg hs;
        begin
            n = 0;
            awaddr <= ad;
            araddr <= ad;
            wdata <= dt;
            awv <= w;
            wv <= w;
            arv <= !w;
            do begin
                @(posedge clk);
                n++;
                if (aw_rdy) awv <= 1'b0;
                if (w_rdy) wv <= 1'b0;
                if (ar_rdy) arv <= 1'b0;
                hs = w ? (bvalid && bready) : (rvalid && rready);
                if (!hs && n > 2) begin
                    bready <= w;
                    rready <= !w;
                end
            end while (!hs && n < 200);
            q = rdata;
            r = w ? bresp : rresp;
            bready <= 1'b0;
            rready <= 1'b0;
            if (n >= 200) begin num_errors++; results; end
            @(posedge clk);
        end
    endtask
    task mode(input reg [1:0] m);
        begin
            axi(0, 8'h08, 0);
            `CHK("mode", m, q[9:8])
        end
    endtask
    initial begin
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        q = $random(seed);
        base = q[7:0];
        axi(0, 8'h00, 0);
        `CHK("ctrl reset", 32'h0, q)
        axi(0, 8'h0c, 0);
        `CHK("unmapped", 2'h2, r)
        axi(1, 8'h04, {24'h0, base});
        `CHK("wr resp", 2'h0, r)
        axi(0, 8'h04, 0);
        `CHK("high base", base, q[7:0])
        $display("test 1 done");
        axi(1, 8'h00, 32'h08);
        for (i = 0; i < 9; i++) begin
            u_host.vs(b);
            `CHK("sync release", 1'b1, b)
        end
        for (i = 0; i < 17; i++) begin
            u_host.vs(b);
            x = mf({base, 7'h0, i > 8});
            if (i != 8) `CHK("ddc1 bit", x[7 - i % 9], b)
        end
        axi(1, 8'h00, 32'h09);
        axi(0, 8'h00, 0);
        `CHK("cfg locked", 3'h0, q[2:0])
        mode(2'h1);
        $display("test 2 done");
        u_host.tick;
        mode(2'h2);
        for (i = 0; i < 6; i++) u_host.tick;
        mode(2'h2);
        repeat (40) @(posedge clk);
        mode(2'h1);
        for (i = 0; i < 8; i++) begin
            u_host.vs(b);
            x = mf({base, 8'h00});
            `CHK("resume bit", x[7 - i], b)
        end
        $display("test 3 done");
        axi(1, 8'h00, 32'h00);
        axi(1, 8'h00, 32'h01);
        axi(1, 8'h00, 32'h29);
        mode(2'h3);
        u_host.start;
        u_host.send(8'ha0, a);
        `CHK("a0 refused", 1'b0, a)
        u_host.stop;
        u_host.start;
        u_host.send(8'ha2, a);
        `CHK("a2 ack", 1'b1, a)
        u_host.send(8'hff, a);
        q = $random(seed);
        d = q[7:0];
        u_host.send(d, a);
        `CHK("data ack", 1'b1, a)
        u_host.stop;
        `CHK("wr addr", {base, 8'hff}, wa)
        `CHK("wr data", d, wd)
        `CHK("end irq", 1'b1, irq)
        u_host.start;
        u_host.send(8'ha3, a);
        `CHK("a3 ack", 1'b1, a)
        u_host.recv(1'b0, x);
        `CHK("read wrap", mf({base, 8'h00}), x)
        u_host.stop;
        axi(1, 8'h00, 32'h39);
        u_host.start;
        u_host.send(8'ha2, a);
        u_host.send(8'h10, a);
        u_host.send(d ^ 8'h5a, a);
        `CHK("wp ack", 1'b1, a)
        u_host.stop;
        `CHK("wp no write", {base, 8'hff}, wa)
        $display("test 4 done");
        results;
    end
endmodule // tb_ddc_hw_iface
